// *** design/abs_store.sv ***
// Battery-backed part of the absolute position system: revolution count,
// home offset and the flags saying whether home is valid or stale.
// Assumes nbat_rst_i falls only when the backup battery is first fitted.
`timescale 1ns/10ps
module abs_store
  import servo_homing_pkg::*;
(
  input  wire logic        clk_i,        // System clock
  input  wire logic        nbat_rst_i,   // Battery domain reset, active low
  input  wire logic        rev_up_i,     // Encoder wrapped forward
  input  wire logic        rev_down_i,   // Encoder wrapped backward
  input  wire logic        battery_ok_i, // Backup battery healthy
  input  wire logic        set_home_i,   // Take home_off_i as home
  input  wire logic [31:0] home_off_i,   // New home offset
  input  wire logic        mark_dirty_i, // A home-related parameter changed
  input  wire logic        power_up_i,   // First cycle after control reset
  output logic      [15:0] revs_o,       // Cumulative revolutions
  output logic      [31:0] home_off_o,   // Stored home offset
  output logic             home_valid_o, // Home position defined
  output logic             dirty_o       // Discard pending at next power-up
);

  store_state_t s;
  store_state_t next_s;

  always_comb begin
    next_s = s;
    if (rev_up_i && !rev_down_i) next_s.revs = s.revs + 16'h0001;
    if (rev_down_i && !rev_up_i) next_s.revs = s.revs - 16'h0001;
    if (mark_dirty_i) next_s.dirty = 1'b1;
    if (power_up_i && s.dirty) begin
      next_s.valid = 1'b0;
      next_s.dirty = mark_dirty_i;
    end
    if (!battery_ok_i) next_s.valid = 1'b0;
    if (set_home_i) begin
      next_s.home_off = home_off_i;
      next_s.valid    = 1'b1;
    end
  end

  // Not cleared by control reset, so home outlives a power cycle
  always_ff @(posedge clk_i or negedge nbat_rst_i) begin
    if (!nbat_rst_i) s <= '0;
    else s <= next_s;
  end

  assign revs_o       = s.revs;
  assign home_off_o   = s.home_off;
  assign home_valid_o = s.valid;
  assign dirty_o      = s.dirty;

endmodule

// *** design/servo_homing_abs_position.sv ***
// Top of the homing and absolute position block: APB registers, homing
// sequencer, position error supervision and alarms.
// Assumes all pins synchronous to clk_i; motor drive is run/direction.
`timescale 1ns/10ps
`include "servo_homing_cfg.svh"
module servo_homing_abs_position
  import servo_homing_pkg::*;
#(
  parameter logic [19:0] REV_MIN_CYCLES = 20'(`REV_MIN_CYCLES)
)(
  input  wire logic        clk_i,                       // 20 MHz clock
  input  wire logic        nrst_i,                      // Control reset, active low
  input  wire logic        nbat_rst_i,                  // Battery reset, active low
  input  wire logic        psel_i,                      // APB select
  input  wire logic        penable_i,                   // APB enable
  input  wire logic        pwrite_i,                    // APB write
  input  wire logic [7:0]  paddr_i,                     // APB byte address
  input  wire logic [31:0] pwdata_i,                    // APB write data
  output logic      [31:0] prdata_o,                    // APB read data
  output logic             pready_o,                    // APB ready
  output logic             pslverr_o,                   // APB error
  input  wire logic        operation_mode_select_one_i, // Mode select 1
  input  wire logic        operation_mode_select_two_i, // Mode select 2
  input  wire logic        proximity_sensor_input_i,    // Sensor active high
  input  wire logic        forward_stroke_end_i,        // Forward end reached
  input  wire logic        reverse_stroke_end_i,        // Reverse end reached
  input  wire logic [15:0] enc_pos_in_rev_i,            // Position in revolution
  input  wire logic        enc_rev_up_i,                // Forward wrap pulse
  input  wire logic        enc_rev_down_i,              // Backward wrap pulse
  input  wire logic        battery_ok_i,                // Backup battery healthy
  output logic             torque_enable_o,             // Motor may make torque
  output logic      [15:0] torque_limit_o,              // Applied torque limit
  output logic             drive_run_o,                 // Motor moving
  output logic             drive_dir_o,                 // 1 forward, 0 reverse
  output logic             excess_error_alarm_o,        // Position gap too large
  output logic             homing_failure_alarm_o,      // Sensor never found
  output logic             abs_counter_warning_o,       // Overspeed on counter
  output logic             abs_erase_alarm_o,           // Battery data lost
  output logic             homing_done_o                // Home position valid
);

  main_state_t s;
  main_state_t next_s;

  logic [15:0] revs;
  logic [31:0] home_off;
  logic        home_valid;
  logic        store_dirty;
  logic        set_home;
  logic        mark_dirty;
  logic        overspeed;
  logic        homing_mode;
  logic        data_set;
  logic [31:0] abs_pos;
  logic [31:0] rel_pos;
  logic [31:0] pos_err;
  logic [31:0] err_mag;
  logic [31:0] rel_mag;
  logic        err_big;
  logic        soft_stop;
  logic        end_home_dir;
  logic        end_back_dir;
  logic        wr_en;
  logic        addr_ok;
  logic [31:0] rd_mux;
  logic        auto_run;

  abs_store u_store (
    .clk_i        (clk_i),
    .nbat_rst_i   (nbat_rst_i),
    .rev_up_i     (enc_rev_up_i),
    .rev_down_i   (enc_rev_down_i),
    .battery_ok_i (battery_ok_i),
    .set_home_i   (set_home),
    .home_off_i   (abs_pos - s.home_data),
    .mark_dirty_i (mark_dirty),
    .power_up_i   (!s.powered),
    .revs_o       (revs),
    .home_off_o   (home_off),
    .home_valid_o (home_valid),
    .dirty_o      (store_dirty)
  );

  speed_monitor #(
    .MIN_CYCLES (REV_MIN_CYCLES)
  ) u_speed (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .rev_evt_i (enc_rev_up_i ^ enc_rev_down_i),
    .enable_i  (s.gear[15:0] <= `GEAR_CMX_LIMIT),
    .ovs_o     (overspeed)
  );

  assign homing_mode  = !operation_mode_select_one_i && !operation_mode_select_two_i;
  assign data_set     = (s.method[3:0] == `METHOD_DATA_SET);
  assign abs_pos      = {revs, enc_pos_in_rev_i};
  assign rel_pos      = abs_pos - home_off;
  assign pos_err      = s.cmd_pos - rel_pos;
  assign err_mag      = pos_err[31] ? (32'h0 - pos_err) : pos_err;
  assign rel_mag      = rel_pos[31] ? (32'h0 - rel_pos) : rel_pos;
  assign err_big      = err_mag > {16'h0000, s.err_lim};
  // Home direction 0 means forward
  assign end_home_dir = s.home_dir ? reverse_stroke_end_i : forward_stroke_end_i;
  assign end_back_dir = s.home_dir ? forward_stroke_end_i : reverse_stroke_end_i;
  // Soft limits only act in automatic mode, never during back-off moves
  assign soft_stop    = s.soft_en && (s.st == ST_IDLE) && !homing_mode
                        && (rel_mag > s.soft_lim);
  assign auto_run     = !homing_mode && home_valid && !s.alarm[`ALM_EXCESS]
                        && !soft_stop && (pos_err != 32'h0);

  assign wr_en = psel_i && penable_i && pwrite_i;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0;
    case (paddr_i)
      `REG_CTRL:      rd_mux = {29'h0, s.home_dir, s.soft_en, 1'b0};
      `REG_METHOD:    rd_mux = {16'h0, s.method};
      `REG_GEAR:      rd_mux = s.gear;
      `REG_CONFIG:    rd_mux = {31'h0, s.rot_dir};
      `REG_HOME_DATA: rd_mux = s.home_data;
      `REG_LIMITS:    rd_mux = {s.err_lim, s.tq_lim};
      `REG_CMD_POS:   rd_mux = s.cmd_pos;
      `REG_SOFT_LIM:  rd_mux = s.soft_lim;
      `REG_STATUS:    rd_mux = {17'h0, s.st, 1'b0, store_dirty, homing_mode,
                                home_valid, s.alarm};
      `REG_ABS_POS:   rd_mux = rel_pos;
      `REG_ALARM:     rd_mux = {28'h0, s.alarm};
      default:        addr_ok = 1'b0;
    endcase
  end

  always_comb begin
    next_s         = s;
    next_s.start   = 1'b0;
    next_s.powered = 1'b1;
    set_home       = 1'b0;
    mark_dirty     = 1'b0;

    // Read data is captured in the setup cycle so it leaves a flop
    if (psel_i && !penable_i && !pwrite_i) next_s.rdata = rd_mux;

    if (wr_en) begin
      case (paddr_i)
        `REG_CTRL: begin
          next_s.start    = pwdata_i[`CTRL_START];
          next_s.soft_en  = pwdata_i[`CTRL_SOFT_EN];
          next_s.home_dir = pwdata_i[`CTRL_HOME_DIR];
        end
        `REG_METHOD:    next_s.method = pwdata_i[15:0];
        `REG_GEAR: begin
          next_s.gear = pwdata_i;
          mark_dirty  = (pwdata_i != s.gear);
        end
        `REG_CONFIG: begin
          next_s.rot_dir = pwdata_i[0];
          mark_dirty     = (pwdata_i[0] != s.rot_dir);
        end
        `REG_HOME_DATA: begin
          next_s.home_data = pwdata_i;
          mark_dirty       = (pwdata_i != s.home_data);
        end
        `REG_LIMITS: begin
          next_s.tq_lim  = pwdata_i[15:0];
          next_s.err_lim = pwdata_i[31:16];
        end
        `REG_CMD_POS:   next_s.cmd_pos = pwdata_i;
        `REG_SOFT_LIM:  next_s.soft_lim = pwdata_i;
        `REG_ALARM:     next_s.alarm = s.alarm & ~pwdata_i[3:0];
        default:        next_s.alarm = s.alarm;
      endcase
    end

    case (s.st)
      ST_IDLE: begin
        if (homing_mode && data_set) begin
          next_s.st = ST_DSET;
        end else if (homing_mode && s.start) begin
          next_s.seen = proximity_sensor_input_i;
          if (proximity_sensor_input_i) next_s.st = ST_BACK;
          else next_s.st = ST_SEEK;
        end
      end
      ST_DSET: begin
        // Sensor and stroke ends play no part here
        if (!homing_mode) next_s.st = ST_IDLE;
        else if (s.start) set_home = 1'b1;
      end
      ST_BACK: begin
        if (!proximity_sensor_input_i) begin
          next_s.st   = ST_HOME;
          next_s.seen = 1'b0;
        end
      end
      ST_SEEK: begin
        if (proximity_sensor_input_i) begin
          next_s.st   = ST_HOME;
          next_s.seen = 1'b1;
        end else if (end_home_dir) begin
          next_s.st   = ST_REV;
          next_s.seen = 1'b0;
        end
      end
      ST_REV: begin
        if (proximity_sensor_input_i) begin
          next_s.seen = 1'b1;
        end else if (s.seen) begin
          next_s.st   = ST_HOME;
          next_s.seen = 1'b0;
        end else if (end_back_dir) begin
          next_s.st = ST_FAIL;
          next_s.alarm[`ALM_HOME_FAIL] = 1'b1;
        end
      end
      ST_HOME: begin
        if (proximity_sensor_input_i) begin
          next_s.seen = 1'b1;
        end else if (s.seen) begin
          set_home  = 1'b1;
          next_s.st = ST_IDLE;
        end else if (end_home_dir) begin
          next_s.st = ST_FAIL;
          next_s.alarm[`ALM_HOME_FAIL] = 1'b1;
        end
      end
      ST_FAIL:  next_s.st = ST_FAIL;
      default:  next_s.st = ST_IDLE;
    endcase
    if (!homing_mode && (s.st != ST_IDLE)) next_s.st = ST_IDLE;

    // Hardware sets are applied last so they win over a software clear
    if (!homing_mode && err_big) next_s.alarm[`ALM_EXCESS] = 1'b1;
    if (overspeed) next_s.alarm[`ALM_COUNTER] = 1'b1;
    if (!battery_ok_i) next_s.alarm[`ALM_ERASE] = 1'b1;
    if (s.st == ST_REV && next_s.st == ST_FAIL) next_s.alarm[`ALM_HOME_FAIL] = 1'b1;
    if (s.st == ST_HOME && next_s.st == ST_FAIL) next_s.alarm[`ALM_HOME_FAIL] = 1'b1;

    // Drive outputs follow the state being entered
    next_s.tq_en  = (next_s.st != ST_DSET);
    next_s.tq_out = (next_s.st == ST_DSET) ? 16'h0000 : s.tq_lim;
    next_s.run    = 1'b0;
    next_s.dir    = s.dir;
    case (next_s.st)
      ST_BACK: begin
        next_s.run = 1'b1;
        next_s.dir = s.home_dir;
      end
      ST_SEEK, ST_HOME: begin
        next_s.run = 1'b1;
        next_s.dir = !s.home_dir;
      end
      ST_REV: begin
        next_s.run = 1'b1;
        next_s.dir = s.home_dir;
      end
      ST_IDLE: begin
        next_s.run = auto_run && !next_s.alarm[`ALM_EXCESS];
        next_s.dir = !pos_err[31];
      end
      default: next_s.run = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s <= '{st: ST_IDLE, gear: `RST_GEAR, tq_lim: `RST_TQ_LIM,
             err_lim: `RST_ERR_LIM, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o               = s.rdata;
  assign pready_o               = 1'b1;
  assign pslverr_o              = psel_i && penable_i && !addr_ok;
  assign torque_enable_o        = s.tq_en;
  assign torque_limit_o         = s.tq_out;
  assign drive_run_o            = s.run;
  assign drive_dir_o            = s.dir;
  assign excess_error_alarm_o   = s.alarm[`ALM_EXCESS];
  assign homing_failure_alarm_o = s.alarm[`ALM_HOME_FAIL];
  assign abs_counter_warning_o  = s.alarm[`ALM_COUNTER];
  assign abs_erase_alarm_o      = s.alarm[`ALM_ERASE];
  assign homing_done_o          = home_valid;

  a_torque_off_dset: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_DSET) |-> (!torque_enable_o && !drive_run_o))
    else $error("torque active in data-setting homing");

  a_no_excess_homing: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (homing_mode && !excess_error_alarm_o) |=> !excess_error_alarm_o)
    else $error("excess error alarm raised in homing mode");

  a_excess_on_exit: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!homing_mode && err_big) |=> excess_error_alarm_o)
    else $error("large gap in automatic mode without alarm");

  a_drive_to_match: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_IDLE && auto_run && !err_big && !pos_err[31])
      |=> (drive_run_o && drive_dir_o))
    else $error("motor not driven toward command");

  a_limit_after_home: assert property (@(posedge clk_i) disable iff (!nrst_i)
    $rose(s.st == ST_DSET) |-> (torque_limit_o == 16'h0000))
    else $error("torque limit applied before data-setting homing completed");

  a_backoff_first: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_IDLE && homing_mode && !data_set && s.start && proximity_sensor_input_i)
      |=> (s.st == ST_BACK) ##0 drive_run_o)
    else $error("no back-off when started on the sensor");

  a_fail_at_end: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s.st == ST_REV && homing_mode && !s.seen && !proximity_sensor_input_i && end_back_dir)
      |=> (homing_failure_alarm_o && !drive_run_o) [*2])
    else $error("stroke end without sensor did not stop with failure alarm");

  a_discard_home: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (!s.powered && store_dirty && !set_home) |=> !home_valid)
    else $error("stale home kept after power-up");

endmodule

// *** design/servo_homing_cfg.svh ***
// Constants of the homing and absolute position block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 20 MHz clock and a 32-bit APB register bus.
// Operation
// - Data-setting homing stops motor torque as soon as homing mode is entered.
// - No excess error alarm while in homing mode, whatever the position gap.
// - On return to automatic mode, a large position gap raises the excess error alarm.
// - Without that alarm, the motor is driven until command and actual positions match.
// - Configured torque limit applies only after data-setting homing has completed; the code applies it in every state except ST_DSET.
// - Data-setting homing ignores the proximity sensor completely.
// - Lowest homing method digit equal to D selects data-setting homing.
// - Data-setting homing takes the shaft's present position as home.
// - Sensor homing started on the sensor first backs off, then homes.
// - Started beyond the sensor, move toward home and reverse at a stroke end.
// - While reversing, stop past the sensor front edge and restart homing there.
// - Sensor never found: stop at the stroke end and raise homing failure alarm.
// - Software position limits are not used together with automatic back-off.
// - Changed gear, direction or home data parameters discard home at next power-up.
// - Gear count up to 2000: speed at or above 3076.7 r/min raises counter warning.
// - Absolute position is in-revolution position plus battery-backed revolution count.
// - Defined home position survives power cycles; no homing needed at power-on.
`ifndef SERVO_HOMING_CFG_SVH
`define SERVO_HOMING_CFG_SVH

`define REG_CTRL        8'h00
`define REG_METHOD      8'h04
`define REG_GEAR        8'h08
`define REG_CONFIG      8'h0c
`define REG_HOME_DATA   8'h10
`define REG_LIMITS      8'h14
`define REG_CMD_POS     8'h18
`define REG_SOFT_LIM    8'h1c
`define REG_STATUS      8'h20
`define REG_ABS_POS     8'h24
`define REG_ALARM       8'h28

`define CTRL_START      0
`define CTRL_SOFT_EN    1
`define CTRL_HOME_DIR   2
`define ALM_EXCESS      0
`define ALM_HOME_FAIL   1
`define ALM_COUNTER     2
`define ALM_ERASE       3

`define RST_GEAR        32'h0001_0001
`define RST_TQ_LIM      16'h03e8
`define RST_ERR_LIM     16'h2710
`define METHOD_DATA_SET 4'hd
`define GEAR_CMX_LIMIT  16'h07d0

`define CLK_HZ          64'h0000_0000_0131_2d00
`define SPEED_LIM_X10   64'h0000_0000_0000_782f
`define SEC_PER_MIN     64'h0000_0000_0000_003c
`define REV_MIN_CYCLES  ((`CLK_HZ * `SEC_PER_MIN * 64'h0a) / `SPEED_LIM_X10)

`endif

// *** design/servo_homing_pkg.sv ***
// Types of the homing and absolute position block.
// Assumes the constants of servo_homing_cfg.svh.
package servo_homing_pkg;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DSET = 7'h02,
    ST_BACK = 7'h04,
    ST_SEEK = 7'h08,
    ST_REV  = 7'h10,
    ST_HOME = 7'h20,
    ST_FAIL = 7'h40
  } home_state_t;

  typedef struct packed {
    home_state_t  st;
    logic         start;
    logic         soft_en;
    logic         home_dir;
    logic [15:0]  method;
    logic [31:0]  gear;
    logic         rot_dir;
    logic [31:0]  home_data;
    logic [15:0]  tq_lim;
    logic [15:0]  err_lim;
    logic [31:0]  cmd_pos;
    logic [31:0]  soft_lim;
    logic [31:0]  rdata;
    logic [3:0]   alarm;
    logic         seen;
    logic         powered;
    logic         run;
    logic         dir;
    logic         tq_en;
    logic [15:0]  tq_out;
  } main_state_t;

  typedef struct packed {
    logic [15:0]  revs;
    logic [31:0]  home_off;
    logic         valid;
    logic         dirty;
  } store_state_t;

  typedef struct packed {
    logic [19:0]  cnt;
    logic         seen;
    logic         ovs;
  } speed_state_t;

endpackage

// *** design/speed_monitor.sv ***
// Overspeed check for the absolute revolution counter: measures cycles
// between revolution wraps and flags an interval that is too short.
// Assumes one wrap pulse per revolution.
`timescale 1ns/10ps
module speed_monitor
  import servo_homing_pkg::*;
#(
  parameter logic [19:0] MIN_CYCLES = 20'h5f38c
)(
  input  wire logic clk_i,     // System clock
  input  wire logic nrst_i,    // Reset, active low
  input  wire logic rev_evt_i, // One revolution completed
  input  wire logic enable_i,  // Check active for this gear range
  output logic      ovs_o      // Overspeed seen, one-cycle pulse
);

  speed_state_t s;
  speed_state_t next_s;

  always_comb begin
    next_s     = s;
    next_s.ovs = 1'b0;
    if (s.cnt != 20'hfffff) next_s.cnt = s.cnt + 20'h00001;
    if (rev_evt_i) begin
      // First wrap after reset has no reference interval
      // Count holds interval minus one, so strict compare means interval <= MIN_CYCLES
      next_s.ovs  = s.seen && enable_i && (s.cnt < MIN_CYCLES);
      next_s.cnt  = 20'h00000;
      next_s.seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) s <= '0;
    else s <= next_s;
  end

  assign ovs_o = s.ovs;

endmodule

// *** tb/mode_master.sv ***
// Model of the fieldbus master that drives the two mode-select inputs.
// Assumes the bench asks for homing mode on home_req_i, synchronous to clk_i.
`timescale 1ns/10ps
module mode_master #(
  parameter int LAT = 4
)(
  input  wire logic clk_i,                       // System clock
  input  wire logic home_req_i,                  // Bench asks for homing mode
  output logic      operation_mode_select_one_o, // Mode select 1
  output logic      operation_mode_select_two_o, // Mode select 2
  output logic      settled_o                    // Requested mode has reached the pins
);
  logic [LAT-1:0] delay_line;

  // Link delay: a mode must be asked for well before anything relies on it
  initial delay_line = '0;
  always @(posedge clk_i) begin
    delay_line <= {delay_line[LAT-2:0], home_req_i};
  end
  assign operation_mode_select_one_o = ~delay_line[LAT-1];
  assign operation_mode_select_two_o = ~delay_line[LAT-1];
  assign settled_o = (delay_line == {LAT{home_req_i}});
endmodule

// *** tb/servo_homing_abs_position_tb_top.sv ***
// Self-checking bench of the homing and absolute position block.
// Assumes the mode master model on the mode pins and zero-wait APB.
`timescale 1ns/10ps
module servo_homing_abs_position_tb_top;
  import servo_homing_pkg::*;
  logic        clk_i, nrst_i, nbat_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic        proximity_sensor_input_i, forward_stroke_end_i, reverse_stroke_end_i;
  logic        enc_rev_up_i, battery_ok_i, home_req, m1, m2, settled;
  logic        tq_en, run, dir, a_exc, a_fail, w_cnt, a_erase, done;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, cmd;
  logic [15:0] enc_pos_in_rev_i, tq_lim;
  logic [32:0] exp_q[$];
  int          fail_count, tests_run;

  servo_homing_abs_position #(.REV_MIN_CYCLES(20'h00014)) i_servo_homing_abs_position (
    .clk_i, .nrst_i, .nbat_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .operation_mode_select_one_i(m1),
    .operation_mode_select_two_i(m2), .proximity_sensor_input_i, .forward_stroke_end_i,
    .reverse_stroke_end_i, .enc_pos_in_rev_i, .enc_rev_up_i, .enc_rev_down_i(1'b0),
    .battery_ok_i, .torque_enable_o(tq_en), .torque_limit_o(tq_lim), .drive_run_o(run),
    .drive_dir_o(dir), .excess_error_alarm_o(a_exc), .homing_failure_alarm_o(a_fail),
    .abs_counter_warning_o(w_cnt), .abs_erase_alarm_o(a_erase), .homing_done_o(done));
  mode_master i_mode_master (.clk_i, .home_req_i(home_req), .operation_mode_select_one_o(m1),
    .operation_mode_select_two_o(m2), .settled_o(settled));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Index: 0 done, 1 run, 2 excess, 3 fail, 4 counter, 5 erase, 6 dir, 7 torque, 8 limit, 9 mode
  function logic [15:0] pick(input int k);
    logic [9:0] v;
    v = {settled, 1'b0, tq_en, dir, a_erase, w_cnt, a_fail, a_exc, run, done};
    pick = (k == 8) ? tq_lim : {15'h0, v[k]};
  endfunction

  task cmp(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task check_rd(input logic [32:0] got, input logic [32:0] exp);
    cmp(got, exp);
  endtask

  task check_out(input int k, input logic [15:0] e);
    @(negedge clk_i);
    cmp({17'h0, pick(k)}, {17'h0, e});
    @(posedge clk_i);
  endtask

  task wait_sig(input int k, input logic v);
    int n;
    n = 0;
    // Never sample in the time step of the edge that launches a change
    @(negedge clk_i);
    while (pick(k) !== {15'h0, v} && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    cmp({17'h0, pick(k)}, {32'h0, v});
    if (n >= 3000) test_done();
    @(posedge clk_i);
  endtask

  // Reads note {pslverr, data} as the expected answer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge clk_i);
    if (!w) exp_q.push_back(e);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      cmp(33'h0, 33'h1);
      test_done();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) check_rd({pslverr_o, prdata_o},
      exp_q.pop_front());
  end

  task pulses(input int gap, input int cnt);
    repeat (cnt) begin
      repeat (gap) @(posedge clk_i);
      enc_rev_up_i <= 1'b1;
      @(posedge clk_i);
      enc_rev_up_i <= 1'b0;
    end
  endtask

  task pwr_cycle;
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
  endtask

  task test_done;
    $display("mismatches %0d comparisons %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {nrst_i, nbat_rst_i, psel_i, penable_i, pwrite_i, home_req} = '0;
    {proximity_sensor_input_i, forward_stroke_end_i, reverse_stroke_end_i, enc_rev_up_i} = '0;
    {paddr_i, pwdata_i, fail_count, tests_run} = '0;
    battery_ok_i = 1'b1;
    enc_pos_in_rev_i = 16'h0100;
    void'($urandom(87460));
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    nbat_rst_i <= 1'b1;
    apb(0, 8'h14, 0, 33'h0_2710_03e8);
    apb(0, 8'h08, 0, 33'h0_0001_0001);
    apb(0, 8'h30, 0, 33'h1_0000_0000);
    apb(1, 8'h04, 32'h0000_000d, 0);
    home_req <= 1'b1;
    wait_sig(9, 1'b1);
    wait_sig(7, 1'b0);
    cmd = 32'h0010_0000 | ($urandom & 32'h000f_ffff);
    apb(1, 8'h18, cmd, 0);
    repeat (20) begin
      @(posedge clk_i);
      proximity_sensor_input_i <= 1'($urandom);
    end
    check_out(1, 16'h0);
    check_out(2, 16'h0);
    apb(1, 8'h00, 32'h1, 0);
    wait_sig(0, 1'b1);
    apb(0, 8'h24, 0, 33'h0);
    home_req <= 1'b0;
    wait_sig(2, 1'b1);
    wait_sig(7, 1'b1);
    check_out(8, 16'h03e8);
    apb(1, 8'h18, 32'h5, 0);
    apb(1, 8'h28, 32'hf, 0);
    wait_sig(1, 1'b1);
    check_out(6, 16'h1);
    enc_pos_in_rev_i <= 16'h0105;
    wait_sig(1, 1'b0);
    pulses(40, 3);
    check_out(4, 16'h0);
    apb(0, 8'h24, 0, {1'b0, {16'h0003, 16'h0105} - 32'h0000_0100});
    pulses(8, 3);
    wait_sig(4, 1'b1);
    apb(1, 8'h04, 32'h0, 0);
    home_req <= 1'b1;
    wait_sig(9, 1'b1);
    apb(1, 8'h28, 32'hf, 0);
    proximity_sensor_input_i <= 1'b1;
    apb(1, 8'h00, 32'h1, 0);
    wait_sig(1, 1'b1);
    proximity_sensor_input_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    proximity_sensor_input_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    proximity_sensor_input_i <= 1'b0;
    wait_sig(1, 1'b0);
    apb(1, 8'h00, 32'h1, 0);
    wait_sig(1, 1'b1);
    check_out(6, 16'h1);
    forward_stroke_end_i <= 1'b1;
    wait_sig(6, 1'b0);
    forward_stroke_end_i <= 1'b0;
    proximity_sensor_input_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    proximity_sensor_input_i <= 1'b0;
    wait_sig(6, 1'b1);
    proximity_sensor_input_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    proximity_sensor_input_i <= 1'b0;
    wait_sig(1, 1'b0);
    apb(1, 8'h00, 32'h1, 0);
    forward_stroke_end_i <= 1'b1;
    wait_sig(6, 1'b0);
    forward_stroke_end_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    reverse_stroke_end_i <= 1'b1;
    wait_sig(3, 1'b1);
    check_out(1, 16'h0);
    reverse_stroke_end_i <= 1'b0;
    pwr_cycle();
    check_out(0, 16'h1);
    apb(1, 8'h08, 32'h0001_0002, 0);
    pwr_cycle();
    check_out(0, 16'h0);
    battery_ok_i <= 1'b0;
    wait_sig(5, 1'b1);
    test_done();
  end
endmodule
